// file: rtl/tmr_pkg.sv
// Shared constants and types of the 16-bit waveform timer.
package tmr_pkg;
    localparam int ADDR_W = 10;
    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IDX_CTRL_A = 8'h80;
    localparam logic [7:0] IDX_CTRL_B = 8'h81;
    localparam logic [7:0] IDX_COUNT = 8'h84;
    localparam logic [7:0] IDX_CAPT = 8'h86;
    localparam logic [7:0] IDX_CMP_A = 8'h88;
    localparam logic [7:0] IDX_CMP_B = 8'h8a;
    localparam logic [7:0] IDX_CMP_C = 8'h8c;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
    localparam logic [7:0] IDX_TICK_DIV = 8'h92;
    localparam logic [7:0] IDX_PIN_DIR = 8'h93;
    localparam int COM_A_LSB = 6;
    localparam int MODE_LO_LSB = 0;
    localparam int MODE_HI_LSB = 3;
    localparam int RUN_BIT = 0;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_MATCH_LSB = 1;
    localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
    localparam logic [7:0] REG8_RST = 8'h00;
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic [15:0] TOP_8B = 16'h00ff;
    localparam logic [15:0] TOP_9B = 16'h01ff;
    localparam logic [15:0] TOP_10B = 16'h03ff;
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [3:0] MODE_NORMAL = 4'h0, MODE_PC8 = 4'h1,
        MODE_PC9 = 4'h2, MODE_PC10 = 4'h3, MODE_CLR_CMPA = 4'h4,
        MODE_FAST8 = 4'h5, MODE_FAST9 = 4'h6, MODE_FAST10 = 4'h7,
        MODE_PFC_CAPT = 4'h8, MODE_PFC_CMPA = 4'h9,
        MODE_PC_CAPT = 4'ha, MODE_PC_CMPA = 4'hb,
        MODE_CLR_CAPT = 4'hc, MODE_RSVD = 4'hd,
        MODE_FAST_CAPT = 4'he, MODE_FAST_CMPA = 4'hf;
    typedef enum logic [1:0] {CLS_NONPWM, CLS_FAST, CLS_DUAL} tmr_cls_t;
    typedef enum logic [1:0] {EV_IMM, EV_TOP, EV_BOT, EV_MAX} tmr_evt_t;
endpackage

// file: rtl/tmr_mode_dec.sv
// Waveform mode decoder: class, TOP source, update and overflow points.
`timescale 1ns/1ns
module tmr_mode_dec
    import tmr_pkg::*;
(
    input logic [3:0] mode,
    input logic [15:0] capt,
    input logic [15:0] cmp_a,
    output tmr_cls_t cls,
    output tmr_evt_t upd,
    output tmr_evt_t ovf,
    output logic [15:0] top,
    output logic tgl_ok
);
    function automatic logic [15:0] fixed_top(input logic [1:0] sel);
        case (sel)
            2'h1: fixed_top = TOP_8B;
            2'h2: fixed_top = TOP_9B;
            default: fixed_top = TOP_10B;
        endcase
    endfunction

    always_comb begin
        cls = CLS_NONPWM;
        upd = EV_IMM;
        ovf = EV_MAX;
        top = TOP_MAX;
        tgl_ok = 1'b0;
        case (mode)
            MODE_PC8, MODE_PC9, MODE_PC10: begin
                cls = CLS_DUAL;
                upd = EV_TOP;
                ovf = EV_BOT;
                top = fixed_top(mode[1:0]);
            end
            MODE_CLR_CMPA: top = cmp_a;
            MODE_CLR_CAPT: top = capt;
            MODE_FAST8, MODE_FAST9, MODE_FAST10: begin
                cls = CLS_FAST;
                upd = EV_TOP;
                ovf = EV_TOP;
                top = fixed_top(mode[1:0]);
            end
            MODE_PFC_CAPT, MODE_PFC_CMPA: begin
                cls = CLS_DUAL;
                upd = EV_BOT;
                ovf = EV_BOT;
                top = mode[0] ? cmp_a : capt;
                tgl_ok = 1'b1;
            end
            MODE_PC_CAPT, MODE_PC_CMPA: begin
                cls = CLS_DUAL;
                upd = EV_TOP;
                ovf = EV_BOT;
                top = mode[0] ? cmp_a : capt;
                tgl_ok = 1'b1;
            end
            MODE_FAST_CAPT, MODE_FAST_CMPA: begin
                cls = CLS_FAST;
                upd = EV_TOP;
                ovf = EV_TOP;
                top = mode[0] ? cmp_a : capt;
                tgl_ok = 1'b1;
            end
            // Normal and the reserved code count freely up to MAX.
            default: top = TOP_MAX;
        endcase
    end
endmodule // tmr_mode_dec

// file: rtl/tmr_wave_ch.sv
// One compare channel: decides the waveform level and pin ownership.
`timescale 1ns/1ns
module tmr_wave_ch
    import tmr_pkg::*;
#(
    parameter logic IS_A = 1'b0
)
(
    input logic clk,
    input logic rst_n,
    input logic [1:0] com,
    input tmr_cls_t cls,
    input logic tgl_ok,
    input logic match,
    input logic at_top,
    input logic down,
    input logic cmp_is_top,
    output logic wave,
    output logic linked
);
    typedef struct packed {
        logic wave;
    } tmr_ch_t;

    tmr_ch_t st_r;
    tmr_ch_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        linked = (com != COM_OFF);
        if (com == COM_TOGGLE && cls != CLS_NONPWM && !(IS_A && tgl_ok)) begin
            linked = 1'b0;
        end
        if (linked) begin
            case (cls)
                CLS_FAST: begin
                    if (com == COM_TOGGLE) begin
                        if (match) begin
                            st_nxt.wave = ~st_r.wave;
                        end
                    end else if (at_top) begin
                        st_nxt.wave = ~com[0];
                    end else if (match && !cmp_is_top) begin
                        st_nxt.wave = com[0];
                    end
                end
                CLS_DUAL: begin
                    if (match && com == COM_TOGGLE) begin
                        st_nxt.wave = ~st_r.wave;
                    end else if (match) begin
                        st_nxt.wave = down ^ com[0];
                    end
                end
                default: begin
                    if (match) begin
                        st_nxt.wave = com[1] ? com[0] : ~st_r.wave;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wave = st_r.wave;
endmodule // tmr_wave_ch

// file: rtl/tmr_wave_top.sv
// Top of the 16-bit waveform timer: register slave, counter and pins.
`timescale 1ns/1ns
module tmr_wave_top
    import tmr_pkg::*;
(
    input logic REF_CLK,
    input logic NRST,
    input logic [ADDR_W-1:0] AWADDR,
    input logic AWVALID,
    output logic AWREADY,
    input logic [31:0] WDATA,
    input logic [3:0] WSTRB,
    input logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input logic BREADY,
    input logic [ADDR_W-1:0] ARADDR,
    input logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input logic RREADY,
    output logic IRQ,
    output logic [2:0] WAVE_OUT,
    output logic [2:0] WAVE_OE_N,
    output logic [2:0] WAVE_OVR
);
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_idx;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] count;
        logic [15:0] capt;
        logic [15:0] div;
        logic [15:0] div_cnt;
        logic [2:0][15:0] cmp_buf;
        logic [2:0][15:0] cmp_act;
        logic down;
        logic tick;
        logic [3:0] stat;
        logic [3:0] mask;
        logic [2:0] dir;
        logic [2:0] pin;
        logic [2:0] oe_n;
        logic [2:0] ovr;
        logic irq;
    } tmr_state_t;

    tmr_state_t st_r;
    tmr_state_t n;
    logic [3:0] mode;
    tmr_cls_t cls;
    tmr_evt_t upd;
    tmr_evt_t ovf;
    logic [15:0] top;
    logic tgl_ok;
    logic [2:0] match;
    logic [2:0] cmp_top;
    logic [2:0] wave;
    logic [2:0] linked;
    logic at_top;
    logic at_bot;
    logic wr_go;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic [15:0] wr16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        wr16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and compare channels.

    assign mode = {st_r.ctrl_b[MODE_HI_LSB +: 2],
                   st_r.ctrl_a[MODE_LO_LSB +: 2]};
    assign at_top = st_r.tick && (st_r.count == top);
    assign at_bot = st_r.tick && (st_r.count == BOTTOM);
    assign wr_go = st_r.aw_got && st_r.w_got;

    tmr_mode_dec u_dec (
        .mode(mode),
        .capt(st_r.capt),
        .cmp_a(st_r.cmp_act[0]),
        .cls(cls),
        .upd(upd),
        .ovf(ovf),
        .top(top),
        .tgl_ok(tgl_ok)
    );

    for (genvar i = 0; i < 3; i++) begin : g_ch
        assign match[i] = st_r.tick && (st_r.count == st_r.cmp_act[i]);
        assign cmp_top[i] = (st_r.cmp_act[i] == top);
        tmr_wave_ch #(.IS_A(i == 0)) u_ch (
            .clk(REF_CLK),
            .rst_n(NRST),
            .com(st_r.ctrl_a[COM_A_LSB - 2*i +: 2]),
            .cls(cls),
            .tgl_ok(tgl_ok),
            .match(match[i]),
            .at_top(at_top),
            .down(st_r.down),
            .cmp_is_top(cmp_top[i]),
            .wave(wave[i]),
            .linked(linked[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode.

    always_comb begin
        rd_hit = 1'b1;
        case (ARADDR[ADDR_W-1:2])
            IDX_CTRL_A: rd_word = {24'h000000, st_r.ctrl_a};
            IDX_CTRL_B: rd_word = {24'h000000, st_r.ctrl_b};
            IDX_COUNT: rd_word = {16'h0000, st_r.count};
            IDX_CAPT: rd_word = {16'h0000, st_r.capt};
            IDX_CMP_A: rd_word = {16'h0000, st_r.cmp_buf[0]};
            IDX_CMP_B: rd_word = {16'h0000, st_r.cmp_buf[1]};
            IDX_CMP_C: rd_word = {16'h0000, st_r.cmp_buf[2]};
            IDX_IRQ_STAT: rd_word = {28'h0000000, st_r.stat};
            IDX_IRQ_MASK: rd_word = {28'h0000000, st_r.mask};
            IDX_TICK_DIV: rd_word = {16'h0000, st_r.div};
            IDX_PIN_DIR: rd_word = {29'h0, st_r.dir};
            default: begin
                rd_word = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [15:0] w16;
        logic [3:0] ev;
        logic [3:0] clr;
        w16 = wr16(REG16_RST, st_r.wdata, st_r.wstrb);
        ev = '0;
        clr = '0;
        n = st_r;
        // Tick divider: the only slower rate, a one-cycle enable.
        n.tick = 1'b0;
        n.div_cnt = REG16_RST;
        if (st_r.ctrl_b[RUN_BIT]) begin
            if (st_r.div_cnt >= st_r.div) begin
                n.tick = 1'b1;
            end else begin
                n.div_cnt = st_r.div_cnt + ONE;
            end
        end
        // Counter advances only on a tick.
        if (st_r.tick) begin
            if (cls == CLS_DUAL) begin
                if (!st_r.down && st_r.count < top) begin
                    n.count = st_r.count + ONE;
                end else begin
                    // TOP was shown for this one tick; turn downward.
                    n.count = (st_r.count == BOTTOM) ? BOTTOM
                                                     : st_r.count - ONE;
                    n.down = (st_r.count > ONE);
                end
            end else begin
                n.down = 1'b0;
                n.count = (st_r.count == top) ? BOTTOM : st_r.count + ONE;
            end
        end
        // Compare buffer transfer; immediate modes track the buffer.
        for (int i = 0; i < 3; i++) begin
            if (upd == EV_IMM || (upd == EV_TOP && at_top) ||
                (upd == EV_BOT && at_bot)) begin
                n.cmp_act[i] = st_r.cmp_buf[i];
            end
            ev[IRQ_MATCH_LSB + i] = match[i];
        end
        case (ovf)
            EV_TOP: ev[IRQ_OVF] = at_top;
            EV_BOT: ev[IRQ_OVF] = at_bot;
            default: ev[IRQ_OVF] = st_r.tick && st_r.count == TOP_MAX;
        endcase
        // Register bus: address and data may arrive in either order.
        if (AWVALID && st_r.awready) begin
            n.aw_got = 1'b1;
            n.aw_idx = AWADDR[ADDR_W-1:2];
        end
        if (WVALID && st_r.wready) begin
            n.w_got = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        if (BREADY && st_r.bvalid) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (st_r.aw_idx)
                IDX_CTRL_A: begin
                    w16 = wr16({8'h00, st_r.ctrl_a}, st_r.wdata, st_r.wstrb);
                    n.ctrl_a = w16[7:0];
                end
                IDX_CTRL_B: begin
                    w16 = wr16({8'h00, st_r.ctrl_b}, st_r.wdata, st_r.wstrb);
                    n.ctrl_b = w16[7:0] & CTRL_B_WMASK;
                end
                IDX_COUNT: n.count = wr16(st_r.count, st_r.wdata, st_r.wstrb);
                IDX_CAPT: n.capt = wr16(st_r.capt, st_r.wdata, st_r.wstrb);
                IDX_CMP_A: n.cmp_buf[0] =
                    wr16(st_r.cmp_buf[0], st_r.wdata, st_r.wstrb);
                IDX_CMP_B: n.cmp_buf[1] =
                    wr16(st_r.cmp_buf[1], st_r.wdata, st_r.wstrb);
                IDX_CMP_C: n.cmp_buf[2] =
                    wr16(st_r.cmp_buf[2], st_r.wdata, st_r.wstrb);
                IDX_IRQ_STAT: clr = st_r.wstrb[0] ? st_r.wdata[3:0] : 4'h0;
                IDX_IRQ_MASK: begin
                    if (st_r.wstrb[0]) begin
                        n.mask = st_r.wdata[3:0];
                    end
                end
                IDX_TICK_DIV: n.div = wr16(st_r.div, st_r.wdata, st_r.wstrb);
                IDX_PIN_DIR: begin
                    if (st_r.wstrb[0]) begin
                        n.dir = st_r.wdata[2:0];
                    end
                end
                default: n.bresp = RESP_SLVERR;
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        if (RREADY && st_r.rvalid) begin
            n.rvalid = 1'b0;
        end
        if (ARVALID && st_r.arready) begin
            n.rvalid = 1'b1;
            n.rdata = rd_word;
            n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        n.arready = !n.rvalid;
        // A new event beats a clear that lands in the same cycle.
        n.stat = (st_r.stat & ~clr) | ev;
        n.irq = |(n.stat & n.mask);
        // Pins are registered so every output leaves a flip-flop.
        n.pin = wave;
        n.ovr = linked;
        n.oe_n = ~(linked & st_r.dir);
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            st_r <= '0;
            st_r.oe_n <= '1;
        end else begin
            st_r <= n;
        end
    end

    assign AWREADY = st_r.awready;
    assign WREADY = st_r.wready;
    assign BRESP = st_r.bresp;
    assign BVALID = st_r.bvalid;
    assign ARREADY = st_r.arready;
    assign RDATA = st_r.rdata;
    assign RRESP = st_r.rresp;
    assign RVALID = st_r.rvalid;
    assign IRQ = st_r.irq;
    assign WAVE_OUT = st_r.pin;
    assign WAVE_OE_N = st_r.oe_n;
    assign WAVE_OVR = st_r.ovr;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    a_count_on_tick: assert property (
        !st_r.tick && !wr_go |=> $stable(st_r.count))
        else $error("count moved without a tick");
    a_pfc_bottom_load: assert property (
        upd == EV_BOT && at_bot
        |=> st_r.cmp_act[1] == $past(st_r.cmp_buf[1]))
        else $error("compare not loaded at bottom");
    a_pfc_hold_between: assert property (
        upd == EV_BOT && !at_bot |=> $stable(st_r.cmp_act[1]))
        else $error("compare loaded away from bottom");
    a_com_b_field: assert property (
        st_r.ctrl_a[5:4] == COM_OFF |-> !linked[1])
        else $error("channel B linked with field off");
    a_override_pin: assert property (
        linked[0] |=> WAVE_OVR[0])
        else $error("override missing");
    a_pin_drive_dir: assert property (
        !WAVE_OE_N[2] |-> $past(linked[2]) && $past(st_r.dir[2]))
        else $error("pin driven without direction");
    a_nonpwm_toggle: assert property (
        cls == CLS_NONPWM && st_r.ctrl_a[7:6] == COM_TOGGLE && match[0]
        |=> wave[0] != $past(wave[0]))
        else $error("no toggle on match");
    a_tgl_b_off: assert property (
        cls != CLS_NONPWM && st_r.ctrl_a[5:4] == COM_TOGGLE |-> !linked[1])
        else $error("channel B toggle in PWM");
    a_fast_top_set: assert property (
        cls == CLS_FAST && st_r.ctrl_a[7:6] == COM_CLEAR && at_top
        |=> wave[0] ##1 WAVE_OUT[0])
        else $error("fast PWM not set at top");
    a_dual_down_set: assert property (
        cls == CLS_DUAL && st_r.ctrl_a[7:6] == COM_CLEAR && match[0]
        && st_r.down |=> wave[0])
        else $error("dual slope not set downward");
    a_dual_top_turn: assert property (
        cls == CLS_DUAL && at_top && !st_r.down && top > ONE && !wr_go
        |=> st_r.down && st_r.count == $past(st_r.count) - ONE)
        else $error("dual slope did not turn at top");
    a_ovf_max_flag: assert property (
        ovf == EV_MAX && st_r.tick && st_r.count == TOP_MAX
        |=> st_r.stat[IRQ_OVF])
        else $error("overflow flag missed at max");

    c_fast_top: cover property (cls == CLS_FAST && at_top);
    c_dual_turn: cover property (cls == CLS_DUAL && at_top ##1 st_r.down);
    c_irq_raised: cover property (!IRQ ##1 IRQ);
endmodule // tmr_wave_top

// file: testbench/test_tmr_wave_top.sv
// Self-checking bench of the waveform timer: register bus, modes and pins.
`timescale 1ns/1ns
module test_tmr_wave_top
    import tmr_pkg::*;
;
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic [ADDR_W-1:0] AWADDR = '0;
    logic [ADDR_W-1:0] ARADDR = '0;
    logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
    logic ARVALID = 1'b0, RREADY = 1'b0;
    logic [31:0] WDATA = '0;
    logic [3:0] WSTRB = '0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic [2:0] WAVE_OUT, WAVE_OE_N, WAVE_OVR;
    int error_cnt = 0;
    int check_count = 0;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [31:0] r;
    logic [3:0] ml;
    logic [1:0] cc;
    logic xa, xb, fs, ds;
    logic [2:0] ex, eo;

    always #20 REF_CLK = ~REF_CLK;

    tmr_wave_top tmr_wave_top_inst (
        .REF_CLK(REF_CLK), .NRST(NRST), .AWADDR(AWADDR),
        .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
        .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
        .RREADY(RREADY), .IRQ(IRQ), .WAVE_OUT(WAVE_OUT),
        .WAVE_OE_N(WAVE_OE_N), .WAVE_OVR(WAVE_OVR)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [33:0] s, input logic [33:0] e);
        check_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [1:0] er);
        wr_q.push_back(er);
        AWADDR <= {idx, 2'b00};
        WDATA <= d;
        WSTRB <= 4'hf;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        // Each channel is released at the edge where its own ready is seen.
        do begin
            @(posedge REF_CLK);
            if (AWREADY === 1'b1) AWVALID <= 1'b0;
            if (WREADY === 1'b1) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [33:0] e);
        rd_q.push_back(e);
        ARADDR <= {idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge REF_CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge REF_CLK); while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        @(posedge REF_CLK);
    endtask

    // Answers are matched against the oldest note left by the driver.
    always @(posedge REF_CLK) begin
        if (RVALID === 1'b1 && RREADY === 1'b1 && rd_q.size() > 0)
            chk({RRESP, RDATA}, rd_q.pop_front());
        if (BVALID === 1'b1 && BREADY === 1'b1 && wr_q.size() > 0)
            chk(34'(BRESP), 34'(wr_q.pop_front()));
    end

    // Counts high cycles per pin; duty ratios do not depend on phase.
    task automatic meas(input int n, input int ea, input int eb, input int ec);
        int c[3] = '{0, 0, 0};
        repeat (n) begin
            @(posedge REF_CLK);
            for (int i = 0; i < 3; i++) c[i] += (WAVE_OUT[i] === 1'b1);
        end
        chk(34'(c[0]), 34'(ea));
        chk(34'(c[1]), 34'(eb));
        chk(34'(c[2]), 34'(ec));
    endtask

    task automatic cmps(input logic [15:0] t, input logic [15:0] a,
                        input logic [15:0] b, input logic [15:0] c);
        wr(IDX_CAPT, {16'h0, t}, RESP_OKAY);
        wr(IDX_CMP_A, {16'h0, a}, RESP_OKAY);
        wr(IDX_CMP_B, {16'h0, b}, RESP_OKAY);
        wr(IDX_CMP_C, {16'h0, c}, RESP_OKAY);
    endtask

    // The counter is zeroed just before CTRL_B is written, so it never starts above TOP.
    task automatic runm(input logic [3:0] m, input logic [7:0] coms);
        wr(IDX_CTRL_A, {24'h0, coms[7:2], m[1:0]}, RESP_OKAY);
        wr(IDX_COUNT, 32'h0, RESP_OKAY);
        wr(IDX_CTRL_B, {27'h0, m[3:2], 3'b001}, RESP_OKAY);
        repeat (40) @(posedge REF_CLK);
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 30000);
        error_cnt++;
        give_verdict();
    end

    initial begin
        void'($urandom(66510));
        repeat (16) @(posedge REF_CLK);
        NRST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        rd(IDX_CTRL_A, 34'h0);
        r = $urandom;
        wr(IDX_CTRL_A, r, RESP_OKAY);
        rd(IDX_CTRL_A, {RESP_OKAY, 24'h0, r[7:0]});
        wr(IDX_CTRL_B, 32'hff, RESP_OKAY);
        rd(IDX_CTRL_B, {RESP_OKAY, 24'h0, CTRL_B_WMASK});
        wr(8'h7f, r, RESP_SLVERR);
        rd(8'h7f, {RESP_SLVERR, 32'h0});
        wr(IDX_PIN_DIR, 32'h5, RESP_OKAY);
        for (int m = 0; m < 16; m++) begin
            for (int c = 0; c < 4; c++) begin
                ml = 4'(m);
                cc = 2'(c);
                wr(IDX_CTRL_B, {27'h0, ml[3:2], 3'b000}, RESP_OKAY);
                wr(IDX_CTRL_A, {24'h0, cc, cc, cc, ml[1:0]}, RESP_OKAY);
                repeat (4) @(posedge REF_CLK);
                fs = ml inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf};
                ds = ml inside {[4'h1:4'h3], [4'h8:4'hb]};
                xa = cc != 2'h0 && !(cc == 2'h1
                    && (fs && ml < 4'he || ds && ml < 4'h8));
                xb = cc != 2'h0 && !(cc == 2'h1 && (fs || ds));
                ex = {xb, xb, xa};
                // Only pins A and C have their direction bit set.
                eo = {~xb, 1'b1, ~xa};
                chk(34'(WAVE_OVR), 34'(ex));
                chk(34'(WAVE_OE_N), 34'(eo));
            end
        end
        wr(IDX_IRQ_STAT, 32'hf, RESP_OKAY);
        cmps(16'h0, 16'h4, 16'h2, 16'h2);
        runm(MODE_CLR_CMPA, 8'h6c);
        meas(100, 50, 0, 100);
        wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
        repeat (3) @(posedge REF_CLK);
        chk(34'(IRQ), 34'h1);
        wr(IDX_CTRL_B, 32'h8, RESP_OKAY);
        rd(IDX_IRQ_STAT, {RESP_OKAY, 32'he});
        wr(IDX_IRQ_MASK, 32'h0, RESP_OKAY);
        repeat (3) @(posedge REF_CLK);
        chk(34'(IRQ), 34'h0);
        wr(IDX_IRQ_MASK, 32'h2, RESP_OKAY);
        wr(IDX_IRQ_STAT, 32'h2, RESP_OKAY);
        repeat (3) @(posedge REF_CLK);
        chk(34'(IRQ), 34'h0);
        rd(IDX_IRQ_STAT, {RESP_OKAY, 32'hc});
        cmps(16'h9, 16'h9, 16'h3, 16'h3);
        runm(MODE_FAST_CAPT, 8'hac);
        meas(100, 100, 40, 60);
        cmps(16'h9, 16'h3, 16'h3, 16'h3);
        runm(MODE_PC_CAPT, 8'hb8);
        meas(180, 60, 120, 60);
        cmps(16'h9, 16'h6, 16'h6, 16'h6);
        runm(MODE_PFC_CAPT, 8'hb8);
        meas(180, 120, 60, 120);
        // Normal mode: only the pass through MAX may raise the overflow bit.
        wr(IDX_CTRL_B, 32'h0, RESP_OKAY);
        wr(IDX_COUNT, 32'hfff0, RESP_OKAY);
        wr(IDX_IRQ_STAT, 32'hf, RESP_OKAY);
        wr(IDX_CTRL_B, 32'h1, RESP_OKAY);
        repeat (40) @(posedge REF_CLK);
        rd(IDX_IRQ_STAT, {RESP_OKAY, 32'hf});
        give_verdict();
    end
endmodule // test_tmr_wave_top
